// file: rtl/aqc_chain_ctl.sv
// acquisition chain control: apb registers, sequencer, analog settings
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "aqc_regs.svh"
module aqc_chain_ctl
  import aqc_pkg::*;
#(
  parameter logic [15:0] SLOW_DIV = 16'(`AQC_SLOW_NS / `AQC_CLK_NS)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        test_mode_pin,
  input  wire logic        mod_bit_pin,
  // sequencing status and events
  output logic             busy,
  output logic             conv_trig,
  output logic             sample_tick,
  output logic             input_chop,
  // bias and enables
  output logic [1:0]       converter_bias_sel,
  output logic [1:0]       amplifier_bias_sel,
  output logic             mod_enable,
  output logic [2:0]       stage_enable,
  output logic [2:0]       stage_bypass,
  // gains and offsets
  output logic             stage1_gain,
  output logic [1:0]       stage2_gain,
  output logic [6:0]       stage3_gain,
  output logic             stage2_ofs_neg,
  output logic [2:0]       stage2_ofs_mag,
  output logic             stage3_ofs_neg,
  output logic [5:0]       stage3_ofs_mag,
  // multiplexers
  output logic [2:0]       analog_pos_sel,
  output logic [2:0]       analog_neg_sel,
  output logic [1:0]       reference_pos_sel,
  output logic [1:0]       reference_neg_sel
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [6:0]        seq_ff;
  aqc_byte_t         bias_ff;
  aqc_byte_t         rate_ff;
  aqc_byte_t         gain_ff;
  logic [6:0]        ofs3_ff;
  logic [5:0]        mux_ff;
  logic [15:0]       res_ff;
  logic              trig_ff;
  logic              pend_ff;
  aqc_state_t        st_ff;
  logic [2:0]        osr_ff;
  logic [1:0]        nelc_ff;
  logic [10:0]       smp_cnt_ff;
  logic [2:0]        elem_cnt_ff;
  logic signed [11:0] acc_ff;
  logic signed [15:0] tot_ff;
  logic              chop_ff;
  logic [31:0]       prdata_ff;
  logic [1:0]        pin_q;
  logic              test_q;
  logic              mod_q;
  logic              hit;
  logic              wr;
  logic              def_wr;
  logic              start_wr;
  logic              go;
  logic              consume;
  logic [31:0]       rd_word;
  logic [10:0]       osr_lim;
  logic [2:0]        elem_lim;
  logic signed [11:0] acc_upd;
  logic signed [15:0] elem_val;
  logic signed [15:0] tot_upd;
  logic signed [31:0] tot_ext;
  logic signed [31:0] mean_w;
  logic signed [31:0] scaled;
  logic [4:0]        shamt;
  logic [15:0]       res_sat;

  aqc_tick_if tk ();

  // ****************************************************************
  // pin synchronisers and sample tick
  // ****************************************************************
  aqc_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       ({test_mode_pin, mod_bit_pin}),
    .q       (pin_q)
  );

  assign test_q = pin_q[1];
  assign mod_q  = pin_q[0];

  assign tk.rate_sel = rate_ff[`AQC_RATE_SEL +: 2];

  aqc_rate_gen #(.SLOW_DIV(SLOW_DIV)) u_rate (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tk      (tk)
  );

  assign sample_tick = tk.tick;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `AQC_OFF_RES_LO: rd_word = {24'h0, res_ff[7:0]};
      `AQC_OFF_RES_HI: rd_word = {24'h0, res_ff[15:8]};
      `AQC_OFF_SEQ:    rd_word = {24'h0, 1'b0, seq_ff};
      `AQC_OFF_BIAS:   rd_word = {24'h0, bias_ff};
      `AQC_OFF_RATE:   rd_word = {24'h0, rate_ff};
      `AQC_OFF_GAIN:   rd_word = {24'h0, gain_ff};
      `AQC_OFF_OFS3:   rd_word = {24'h0, 1'b0, ofs3_ff};
      `AQC_OFF_MUX:    rd_word = {24'h0, busy, 1'b0, mux_ff};
      default:         hit     = 1'b0;
    endcase
  end

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign wr       = psel & penable & pwrite & hit;
  assign def_wr   = wr & (paddr == `AQC_OFF_MUX) & pwdata[`AQC_MUX_DEF];
  assign start_wr = wr & (paddr == `AQC_OFF_SEQ) & pwdata[`AQC_SEQ_START];
  assign prdata   = prdata_ff;

  // read data is captured in the setup cycle so it is stable in access
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rd_word;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seq_ff <= `AQC_SEQ_RST;
    end else if (def_wr) begin
      seq_ff <= `AQC_SEQ_RST;
    end else if (wr && paddr == `AQC_OFF_SEQ) begin
      seq_ff <= {pwdata[6:1], pwdata[`AQC_SEQ_TEST] & test_q};
    end else if (!test_q) begin
      seq_ff[`AQC_SEQ_TEST] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bias_ff <= `AQC_BIAS_RST;
    end else if (def_wr) begin
      bias_ff <= `AQC_BIAS_DEF;
    end else if (wr && paddr == `AQC_OFF_BIAS) begin
      bias_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rate_ff <= 8'h00;
      gain_ff <= 8'h00;
      ofs3_ff <= 7'h00;
    end else if (def_wr) begin
      rate_ff <= 8'h00;
      gain_ff <= 8'h00;
      ofs3_ff <= 7'h00;
    end else if (wr) begin
      if (paddr == `AQC_OFF_RATE) begin
        rate_ff <= pwdata[7:0];
      end
      if (paddr == `AQC_OFF_GAIN) begin
        gain_ff <= pwdata[7:0];
      end
      if (paddr == `AQC_OFF_OFS3) begin
        ofs3_ff <= pwdata[6:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mux_ff <= 6'h00;
    end else if (def_wr) begin
      mux_ff <= 6'h00;
    end else if (wr && paddr == `AQC_OFF_MUX) begin
      mux_ff <= pwdata[5:0];
    end
  end

  // ****************************************************************
  // conversion request
  // ****************************************************************
  assign go      = pend_ff | seq_ff[`AQC_SEQ_CONT];
  assign consume = (st_ff != aqc_st_run) & go & ~def_wr;

  // a new request in the cycle of consumption is kept: set wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
    end else if (def_wr) begin
      pend_ff <= 1'b0;
    end else if (start_wr) begin
      pend_ff <= 1'b1;
    end else if (consume) begin
      pend_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  assign osr_lim  = 11'(11'd1 << (`AQC_OSR_BASE + osr_ff));
  assign elem_lim = 3'((4'd1 << nelc_ff) - 4'd1);
  assign acc_upd  = acc_ff + (mod_q ? 12'sd1 : -12'sd1);
  assign elem_val = chop_ff ? -16'(acc_upd) : 16'(acc_upd);
  assign tot_upd  = tot_ff + elem_val;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff       <= aqc_st_idle;
      osr_ff      <= `AQC_OSR_DEF;
      nelc_ff     <= `AQC_NELC_DEF;
      smp_cnt_ff  <= 11'h000;
      elem_cnt_ff <= 3'h0;
      acc_ff      <= 12'sh000;
      tot_ff      <= 16'sh0000;
      chop_ff     <= 1'b0;
    end else if (def_wr) begin
      st_ff       <= aqc_st_run;
      osr_ff      <= `AQC_OSR_DEF;
      nelc_ff     <= `AQC_NELC_DEF;
      smp_cnt_ff  <= 11'h000;
      elem_cnt_ff <= 3'h0;
      acc_ff      <= 12'sh000;
      tot_ff      <= 16'sh0000;
      chop_ff     <= 1'b0;
    end else begin
      case (st_ff)
        aqc_st_idle, aqc_st_done: begin
          if (go) begin
            st_ff       <= aqc_st_run;
            osr_ff      <= seq_ff[`AQC_SEQ_OSR +: 3];
            nelc_ff     <= seq_ff[`AQC_SEQ_NELC +: 2];
            smp_cnt_ff  <= 11'h000;
            elem_cnt_ff <= 3'h0;
            acc_ff      <= 12'sh000;
            tot_ff      <= 16'sh0000;
            chop_ff     <= 1'b0;
          end else begin
            st_ff <= aqc_st_idle;
          end
        end
        aqc_st_run: begin
          if (tk.tick) begin
            if (smp_cnt_ff == osr_lim) begin
              smp_cnt_ff  <= 11'h000;
              acc_ff      <= 12'sh000;
              tot_ff      <= tot_upd;
              chop_ff     <= ~chop_ff;
              elem_cnt_ff <= elem_cnt_ff + 3'd1;
              if (elem_cnt_ff == elem_lim) begin
                st_ff <= aqc_st_done;
              end
            end else begin
              // first period of each elementary conversion is its reset
              smp_cnt_ff <= smp_cnt_ff + 11'd1;
              if (smp_cnt_ff != 11'h000) begin
                acc_ff <= acc_upd;
              end
            end
          end
        end
        default: begin
          st_ff <= aqc_st_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // result and trigger
  // ****************************************************************
  assign tot_ext = 32'(tot_ff);
  assign mean_w  = tot_ext >>> nelc_ff;
  assign shamt   = `AQC_RES_SHIFT - {2'b00, osr_ff};
  assign scaled  = mean_w <<< shamt;

  always_comb begin
    if (scaled > 32'sd32767) begin
      res_sat = 16'h7fff;
    end else if (scaled < -32'sd32768) begin
      res_sat = 16'h8000;
    end else begin
      res_sat = scaled[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_ff  <= 16'h0000;
      trig_ff <= 1'b0;
    end else if (st_ff == aqc_st_done && !def_wr) begin
      res_ff  <= res_sat;
      trig_ff <= 1'b1;
    end else begin
      trig_ff <= 1'b0;
    end
  end

  assign conv_trig  = trig_ff;
  assign busy       = (st_ff != aqc_st_idle);
  assign input_chop = chop_ff;

  // ****************************************************************
  // analog settings
  // ****************************************************************
  assign converter_bias_sel = bias_ff[`AQC_BIAS_CONV +: 2];
  assign amplifier_bias_sel = bias_ff[`AQC_BIAS_AMP +: 2];
  assign mod_enable         = bias_ff[0];
  assign stage_enable       = bias_ff[3:1];
  assign stage_bypass       = ~bias_ff[3:1];
  assign stage1_gain        = gain_ff[`AQC_GAIN_G1];
  assign stage2_gain        = rate_ff[`AQC_RATE_G2 +: 2];
  assign stage3_gain        = gain_ff[6:0];
  assign stage2_ofs_neg     = rate_ff[3];
  // magnitudes above five steps would pass +/-1, so they are clamped
  assign stage2_ofs_mag     = (rate_ff[2:0] > `AQC_OFS2_MAX) ?
                              `AQC_OFS2_MAX : rate_ff[2:0];
  assign stage3_ofs_neg     = ofs3_ff[6];
  assign stage3_ofs_mag     = ofs3_ff[5:0];

  // ****************************************************************
  // input and reference multiplexers
  // ****************************************************************
  always_comb begin
    logic [2:0] p;
    logic [2:0] n;
    p = 3'h0;
    n = 3'h0;
    if (mux_ff[5]) begin
      p = mux_ff[3:1];
      n = 3'h0;
    end else begin
      p = {mux_ff[2:1], 1'b1};
      n = {mux_ff[2:1], 1'b0};
    end
    if (mux_ff[4]) begin
      analog_pos_sel = n;
      analog_neg_sel = p;
    end else begin
      analog_pos_sel = p;
      analog_neg_sel = n;
    end
  end

  assign reference_pos_sel = {mux_ff[`AQC_MUX_REF], 1'b1};
  assign reference_neg_sel = {mux_ff[`AQC_MUX_REF], 1'b0};

endmodule : aqc_chain_ctl

// file: rtl/aqc_pkg.sv
// types shared by the chain control modules
package aqc_pkg;

  typedef enum logic [2:0] {
    aqc_st_idle = 3'b001,
    aqc_st_run  = 3'b010,
    aqc_st_done = 3'b100
  } aqc_state_t;

  typedef logic [7:0] aqc_byte_t;

endpackage : aqc_pkg

// file: rtl/aqc_rate_gen.sv
// sampling tick divider from the oscillator clock
`timescale 1ns/10ps
`include "aqc_regs.svh"
module aqc_rate_gen #(
  parameter logic [15:0] SLOW_DIV = 16'd25000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // rate selection and tick
  aqc_tick_if.gen   tk
);

  logic [15:0] cnt_ff;
  logic [15:0] lim;
  logic        tick_ff;

  always_comb begin
    case (tk.rate_sel)
      2'b00:   lim = `AQC_DIV_QUARTER - 16'd1;
      2'b01:   lim = `AQC_DIV_EIGHTH - 16'd1;
      2'b10:   lim = `AQC_DIV_THIRTY2 - 16'd1;
      default: lim = SLOW_DIV - 16'd1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= lim) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 16'd1;
      tick_ff <= 1'b0;
    end
  end

  assign tk.tick = tick_ff;

endmodule : aqc_rate_gen

// file: rtl/aqc_regs.svh
// register map, field positions, reset values and timing of the chain control
`ifndef AQC_REGS_SVH
`define AQC_REGS_SVH

// ****************************************************************
// byte offsets on the apb bus
// ****************************************************************
`define AQC_OFF_RES_LO   8'h00
`define AQC_OFF_RES_HI   8'h04
`define AQC_OFF_SEQ      8'h08
`define AQC_OFF_BIAS     8'h0c
`define AQC_OFF_RATE     8'h10
`define AQC_OFF_GAIN     8'h14
`define AQC_OFF_OFS3     8'h18
`define AQC_OFF_MUX      8'h1c

// ****************************************************************
// field positions
// ****************************************************************
`define AQC_SEQ_START    7
`define AQC_SEQ_NELC     5
`define AQC_SEQ_OSR      2
`define AQC_SEQ_CONT     1
`define AQC_SEQ_TEST     0
`define AQC_BIAS_CONV    6
`define AQC_BIAS_AMP     4
`define AQC_RATE_SEL     6
`define AQC_RATE_G2      4
`define AQC_GAIN_G1      7
`define AQC_MUX_BUSY     7
`define AQC_MUX_DEF      6
`define AQC_MUX_IN       1
`define AQC_MUX_REF      0

// ****************************************************************
// reset and default values
// ****************************************************************
`define AQC_SEQ_RST      7'h28
`define AQC_BIAS_RST     8'hf0
`define AQC_BIAS_DEF     8'hf1
`define AQC_NELC_DEF     2'h1
`define AQC_OSR_DEF      3'h2
`define AQC_OFS2_MAX     3'h5

// ****************************************************************
// timing
// ****************************************************************
`define AQC_CLK_NS       5
`define AQC_SLOW_NS      125000
`define AQC_DIV_QUARTER  16'h0004
`define AQC_DIV_EIGHTH   16'h0008
`define AQC_DIV_THIRTY2  16'h0020
`define AQC_OSR_BASE     3
`define AQC_RES_SHIFT    5'h0c

`endif

// file: rtl/aqc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module aqc_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : aqc_sync

// file: rtl/aqc_tick_if.sv
// sampling rate selection and sample tick between control and divider
`timescale 1ns/10ps
interface aqc_tick_if;
  logic [1:0] rate_sel;
  logic       tick;
  modport ctl (output rate_sel, input tick);
  modport gen (input rate_sel, output tick);
endinterface : aqc_tick_if

// file: sim/aqc_chain_chk.sv
// concurrent checks on the chain control ports
`timescale 1ns/10ps
module aqc_chain_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // observed outputs
  input wire logic [31:0] prdata,
  input wire logic        busy,
  input wire logic        conv_trig,
  input wire logic        sample_tick,
  input wire logic        input_chop,
  input wire logic [2:0]  stage_enable,
  input wire logic [2:0]  stage_bypass,
  input wire logic [2:0]  stage2_ofs_mag,
  input wire logic [2:0]  analog_pos_sel,
  input wire logic [2:0]  analog_neg_sel,
  input wire logic [1:0]  reference_pos_sel,
  input wire logic [1:0]  reference_neg_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // shortest conversion is far longer than eight cycles
  sequence quiet_s;
    !conv_trig [*8];
  endsequence

  bypass_inv_a: assert property (stage_bypass == ~stage_enable)
    else $error("bypass is not the inverse of enable");
  trig_gap_a: assert property (conv_trig |=> quiet_s)
    else $error("trigger pulses too close");
  trig_busy_a: assert property (conv_trig |-> $past(busy))
    else $error("trigger without a running conversion");
  busy_end_a: assert property ($fell(busy) |-> conv_trig)
    else $error("busy ended without trigger");
  ref_pair_a: assert property (reference_neg_sel[0] == 1'b0 &&
    reference_pos_sel == {reference_neg_sel[1], 1'b1})
    else $error("reference pair wrong");
  ofs2_max_a: assert property (stage2_ofs_mag <= 3'h5)
    else $error("stage2 offset above range");
  tick_pulse_a: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than a cycle");
  in_pair_a: assert property (analog_pos_sel == 3'h0 ||
    analog_neg_sel == 3'h0 ||
    (analog_pos_sel[2:1] == analog_neg_sel[2:1] &&
     analog_pos_sel[0] != analog_neg_sel[0]))
    else $error("analog pair wrong");
  rd_upper_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chop_start_a: assert property ($rose(busy) |-> !input_chop)
    else $error("conversion started with chopped input");
endmodule : aqc_chain_chk

bind aqc_chain_ctl aqc_chain_chk u_chk (.clk_sys, .nrst, .prdata,
  .busy, .conv_trig, .sample_tick, .input_chop, .stage_enable,
  .stage_bypass,
  .stage2_ofs_mag, .analog_pos_sel, .analog_neg_sel,
  .reference_pos_sel, .reference_neg_sel);

// file: sim/aqc_chain_ctl_test.sv
// self-checking bench for the chain control
`timescale 1ns/10ps
`include "aqc_regs.svh"
module aqc_chain_ctl_test;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, busy;
  logic test_mode_pin, mod_bit_pin, conv_trig, sample_tick, level;
  logic input_chop, mod_enable, stage1_gain, stage2_ofs_neg, err;
  logic stage3_ofs_neg;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [1:0] converter_bias_sel, amplifier_bias_sel, stage2_gain;
  logic [2:0] stage_enable, stage_bypass, stage2_ofs_mag, p, n;
  logic [6:0] stage3_gain;
  logic [5:0] stage3_ofs_mag;
  logic [2:0] analog_pos_sel, analog_neg_sel;
  logic [1:0] reference_pos_sel, reference_neg_sel;
  int n_errors = 0, n_compared = 0, cyc, k;
  int dv[4] = '{4, 8, 32, 16};
  logic [7:0] cv[5] = '{8'h01, 8'h48, 8'h81, 8'hc0, 8'h0f};

  aqc_chain_ctl #(.SLOW_DIV(16'h0010)) u_dut (.clk_sys, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .test_mode_pin, .mod_bit_pin, .busy, .conv_trig, .sample_tick,
    .input_chop, .converter_bias_sel, .amplifier_bias_sel, .mod_enable,
    .stage_enable, .stage_bypass, .stage1_gain, .stage2_gain,
    .stage3_gain, .stage2_ofs_neg, .stage2_ofs_mag, .stage3_ofs_neg,
    .stage3_ofs_mag, .analog_pos_sel, .analog_neg_sel,
    .reference_pos_sel, .reference_neg_sel);
  aqc_mod_src u_src (.clk_sys, .level, .input_chop, .mod_bit_pin);

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string s, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, d);
    int i;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      stop_test();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // idle cycle: outputs written at the access edge settle before checks
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg%h", a), {8'h0, e}, {8'h0, q});
  endtask : rd

  // counts cycles until a trigger pulse, up to a bound
  task automatic wait_trig(input int lim);
    cyc = 0;
    do begin
      @(posedge clk_sys);
      cyc++;
    end while (conv_trig !== 1'b1 && cyc < lim);
    if (cyc >= lim) begin
      n_errors++;
      stop_test();
    end
  endtask : wait_trig

  task automatic cnt_trig(input int m);
    k = 0;
    repeat (m) begin
      @(posedge clk_sys);
      if (conv_trig === 1'b1) k++;
    end
  endtask : cnt_trig

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    test_mode_pin = 0; level = 1;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(`AQC_OFF_SEQ, 8'h28);
    rd(`AQC_OFF_BIAS, 8'hf0);
    rd(`AQC_OFF_RATE, 8'h00);
    rd(`AQC_OFF_MUX, 8'h00);
    chk("bypass", 16'h7, stage_bypass);
    apb(1'b0, 8'h20, 8'h00);
    chk("slverr", 16'h1, err);
    apb(1'b1, `AQC_OFF_BIAS, 8'h5a);
    rd(`AQC_OFF_BIAS, 8'h5a);
    chk("cbias", 16'h1, converter_bias_sel);
    chk("abias", 16'h1, amplifier_bias_sel);
    chk("enab", 16'ha, {stage_enable, mod_enable});
    apb(1'b1, `AQC_OFF_RATE, 8'h6b);
    chk("g2", 16'h2, stage2_gain);
    chk("ofs2", 16'hb, {stage2_ofs_neg, stage2_ofs_mag});
    apb(1'b1, `AQC_OFF_GAIN, 8'hff);
    chk("g13", 16'hff, {stage1_gain, stage3_gain});
    apb(1'b1, `AQC_OFF_OFS3, 8'hff);
    rd(`AQC_OFF_OFS3, 8'h7f);
    chk("ofs3", 16'h7f, {stage3_ofs_neg, stage3_ofs_mag});
    apb(1'b1, `AQC_OFF_SEQ, 8'h29);
    rd(`AQC_OFF_SEQ, 8'h28);
    test_mode_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, `AQC_OFF_SEQ, 8'h29);
    rd(`AQC_OFF_SEQ, 8'h29);
    test_mode_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(`AQC_OFF_SEQ, 8'h28);
    for (int c = 0; c < 64; c++) begin
      apb(1'b1, `AQC_OFF_MUX, 8'(c));
      p = c[5] ? c[3:1] : {c[2:1], 1'b1};
      n = c[5] ? 3'h0 : {c[2:1], 1'b0};
      if (c[4]) {p, n} = {n, p};
      chk("mux", {10'h0, p, n}, {10'h0, analog_pos_sel,
        analog_neg_sel});
      chk("ref", c[0] ? 16'he : 16'h4,
        {reference_pos_sel, reference_neg_sel});
    end
    // rate and ratio sweep, one elementary conversion each; the source saturates the result
    foreach (cv[i]) begin
      level <= cv[i][0];
      apb(1'b1, `AQC_OFF_RATE, {cv[i][7:6], 6'h0});
      apb(1'b1, `AQC_OFF_SEQ, {1'b1, cv[i][5:1], 2'h0});
      k = dv[cv[i][7:6]] * (1 << cv[i][5:4]) * ((8 << cv[i][3:1]) + 1);
      rd(`AQC_OFF_SEQ, {1'b0, cv[i][5:1], 2'h0});
      chk("busy", 16'h1, busy);
      wait_trig(k + 100);
      chk("time", 16'h1, cyc + dv[cv[i][7:6]] >= k &&
        cyc <= k + 60);
      @(posedge clk_sys);
      chk("idle", 16'h0, busy);
      apb(1'b0, `AQC_OFF_RES_LO, 8'h00);
      p = cv[i][0] ? 3'h7 : 3'h0;
      chk("res_lo", {13'h0, p}, {13'h0, q[2:0]});
      apb(1'b0, `AQC_OFF_RES_HI, 8'h00);
      chk("res_hi", cv[i][0] ? 16'h7f : 16'h80, {8'h0, q});
    end
    apb(1'b1, `AQC_OFF_RATE, 8'h00);
    level <= 1'b1;
    repeat (3) apb(1'b1, `AQC_OFF_SEQ, 8'h80);
    cnt_trig(200);
    chk("queued", 16'h2, 16'(k));
    apb(1'b1, `AQC_OFF_SEQ, 8'h02);
    cnt_trig(200);
    chk("cont", 16'h1, k >= 4);
    apb(1'b1, `AQC_OFF_SEQ, 8'h00);
    cnt_trig(60);
    chk("stop", 16'h0, busy);
    apb(1'b1, `AQC_OFF_SEQ, 8'h90);
    repeat (20) @(posedge clk_sys);
    apb(1'b1, `AQC_OFF_MUX, 8'h40);
    rd(`AQC_OFF_SEQ, 8'h28);
    rd(`AQC_OFF_BIAS, 8'hf1);
    rd(`AQC_OFF_GAIN, 8'h00);
    rd(`AQC_OFF_MUX, 8'h80);
    wait_trig(400);
    chk("deftime", 16'h1, cyc >= 230 && cyc <= 290);
    // two chopped elementary conversions only add up if the chop is undone
    rd(`AQC_OFF_RES_HI, 8'h7f);
    stop_test();
  end
endmodule : aqc_chain_ctl_test

// file: sim/aqc_mod_src.sv
// modulator bitstream source standing in for the analog front end
`timescale 1ns/10ps
module aqc_mod_src (
  // clock
  input wire logic clk_sys,
  // input level and chop state
  input wire logic level,
  input wire logic input_chop,
  // bitstream
  output logic     mod_bit_pin = 1'b0
);
  // chopping flips the bitstream; the chain must undo it
  always @(posedge clk_sys) begin
    mod_bit_pin <= level ^ input_chop;
  end
endmodule : aqc_mod_src
